// *** rtl/gpd_top.sv ***
`timescale 1ns/10ps
`include "gpd_consts.svh"
module gpd_top
  import gpd_pkg::*;
#(
  parameter int NPORT = 6,
  parameter int SLOW_DIV = 4096
)(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic stop_mode,
  input wire logic [8*NPORT-1:0] pin_in,
  output logic [8*NPORT-1:0] pin_out,
  output logic [8*NPORT-1:0] pin_oe,
  output logic [8*NPORT-1:0] pin_pullup,
  output logic [8*NPORT-1:0] pin_func_sel,
  output logic [7:0] key_wake_inputs
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_q, rst_n_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [NPORT-1:0][7:0] data;
    logic [NPORT-1:0][7:0] dir;
    logic [NPORT-1:0][7:0] pu;
    logic [NPORT-1:0][7:0] od;
    logic [NPORT-1:0][7:0] fsel;
    logic [7:0] port0_debounce_control;
    logic [7:0] port1_debounce_enables;
    logic [11:0] div;
    logic tick;
    logic [7:0] rdata;
    logic [NPORT-1:0][7:0] o;
    logic [NPORT-1:0][7:0] oe;
    logic [NPORT-1:0][7:0] pull;
    logic [7:0] key;
  } gpd_state_type;
  gpd_state_type s_q, s_d;

  // Net, since each bit has its own driver in the generate below
  wire logic [NPORT-1:0][7:0] filt_lv;
  gpd_debounce_clock_select_type dbsel;
  assign dbsel = gpd_debounce_clock_select_type'(s_q.port0_debounce_control[`GPD_DEBOUNCE_CLOCK_SELECT_HI:`GPD_DEBOUNCE_CLOCK_SELECT_LO]);

  // ----------------------------------------
  // Debounce filters: port 0 pins 0, 5 and all of port 1
  // ----------------------------------------
  genvar gp, gb;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      for (gb = 0; gb < 8; gb++) begin : g_bit
        if ((gp == 0 && (gb == 0 || gb == 5)) || gp == 1) begin : g_db
          logic en;
          if (gp == 1) begin : g_p1
            assign en = s_q.port1_debounce_enables[gb];
          end else if (gb == 5) begin : g_p05
            assign en = s_q.port0_debounce_control[`GPD_PIN5_EN_BIT];
          end else begin : g_p00
            assign en = s_q.port0_debounce_control[`GPD_PIN0_EN_BIT];
          end
          gpd_filter u_filt (
            .clk(clk),
            .rst_n(rst_n_q),
            .pin_in(pin_in[8*gp+gb]),
            .sample_en(s_q.tick),
            .filter_en(en),
            .stop_mode(stop_mode),
            .pin_out(filt_lv[gp][gb])
          );
        end else begin : g_raw
          assign filt_lv[gp][gb] = pin_in[8*gp+gb];
        end
      end
    end
  endgenerate

  // Read value: output pins show the latch, inputs show filtered level
  function automatic logic [7:0] port_read(input logic [7:0] d, input logic [7:0] dr, input logic [7:0] lv);
    port_read = (d & dr) | (lv & ~dr);
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    // Sample tick divider; reserved code gives no ticks so filters just hold
    s_d.tick = 1'b0;
    case (dbsel)
      GPD_DB_FX1: begin
        s_d.tick = 1'b1;
        s_d.div = 12'd0;
      end
      GPD_DB_FX4: begin
        s_d.tick = (s_q.div >= `GPD_DIV_FX4 - 12'd1);
        s_d.div = s_d.tick ? 12'd0 : s_q.div + 12'd1;
      end
      GPD_DB_FX4096: begin
        s_d.tick = (s_q.div >= 12'(SLOW_DIV - 1));
        s_d.div = s_d.tick ? 12'd0 : s_q.div + 12'd1;
      end
      default: begin
        s_d.div = 12'd0;
      end
    endcase
    // Register writes
    if (sfr_wr) begin
      for (int p = 0; p < NPORT; p++) begin
        if (sfr_addr == port_addr(p, 0)) s_d.data[p] = sfr_wdata;
        if (sfr_addr == port_addr(p, 1)) s_d.dir[p] = sfr_wdata;
        if (sfr_addr == port_addr(p, 2)) s_d.pu[p] = sfr_wdata;
        if (sfr_addr == port_addr(p, 3)) s_d.od[p] = sfr_wdata;
        if (p != 1 && sfr_addr == port_addr(p, 4)) begin
          s_d.fsel[p] = (p == 0) ? (sfr_wdata & `GPD_P0FSEL_MASK) : sfr_wdata;
        end
      end
      if (sfr_addr == `GPD_A_P0_DB) s_d.port0_debounce_control = sfr_wdata & `GPD_PORT0_DEBOUNCE_CONTROL_MASK;
      if (sfr_addr == `GPD_A_P1_DB) s_d.port1_debounce_enables = sfr_wdata;
    end
    // Registered read data, unmapped reads zero
    s_d.rdata = `GPD_RST_BYTE;
    if (sfr_rd) begin
      for (int p = 0; p < NPORT; p++) begin
        if (sfr_addr == port_addr(p, 0)) s_d.rdata = port_read(s_q.data[p], s_q.dir[p], filt_lv[p]);
        if (sfr_addr == port_addr(p, 1)) s_d.rdata = s_q.dir[p];
        if (sfr_addr == port_addr(p, 2)) s_d.rdata = s_q.pu[p];
        if (sfr_addr == port_addr(p, 3)) s_d.rdata = s_q.od[p];
        if (p != 1 && sfr_addr == port_addr(p, 4)) s_d.rdata = s_q.fsel[p];
      end
      if (sfr_addr == `GPD_A_P0_DB) s_d.rdata = s_q.port0_debounce_control & `GPD_PORT0_DEBOUNCE_CONTROL_MASK;
      if (sfr_addr == `GPD_A_P1_DB) s_d.rdata = s_q.port1_debounce_enables;
    end
    // Pin drivers: open-drain drives only the low level
    for (int p = 0; p < NPORT; p++) begin
      s_d.o[p] = s_q.data[p] & ~s_q.od[p];
      s_d.oe[p] = s_q.dir[p] & ~(s_q.od[p] & s_q.data[p]);
      s_d.pull[p] = s_q.pu[p];
    end
    // Key inputs gated by direction; output pins read as idle high
    s_d.key = filt_lv[1] | s_q.dir[1];
  end

  // Address lookup per port and register kind
  function automatic logic [7:0] port_addr(input int p, input int k);
    logic [7:0] a;
    a = 8'hff;
    case (p)
      0: a = (k == 0) ? `GPD_A_P0_DATA : (k == 1) ? `GPD_A_P0_DIR : (k == 2) ? `GPD_A_P0_PU :
             (k == 3) ? `GPD_A_P0_OD : `GPD_A_P0_FSEL;
      1: a = (k == 0) ? `GPD_A_P1_DATA : (k == 1) ? `GPD_A_P1_DIR : (k == 2) ? `GPD_A_P1_PU :
             (k == 3) ? `GPD_A_P1_OD : 8'hff;
      2: a = (k == 0) ? `GPD_A_P2_DATA : (k == 1) ? `GPD_A_P2_DIR : (k == 2) ? `GPD_A_P2_PU :
             (k == 3) ? `GPD_A_P2_OD : `GPD_A_P2_FSEL;
      3: a = (k == 0) ? `GPD_A_P3_DATA : (k == 1) ? `GPD_A_P3_DIR : (k == 2) ? `GPD_A_P3_PU :
             (k == 3) ? `GPD_A_P3_OD : `GPD_A_P3_FSEL;
      4: a = (k == 0) ? `GPD_A_P4_DATA : (k == 1) ? `GPD_A_P4_DIR : (k == 2) ? `GPD_A_P4_PU :
             (k == 3) ? `GPD_A_P4_OD : `GPD_A_P4_FSEL;
      5: a = (k == 0) ? `GPD_A_P5_DATA : (k == 1) ? `GPD_A_P5_DIR : (k == 2) ? `GPD_A_P5_PU :
             (k == 3) ? `GPD_A_P5_OD : `GPD_A_P5_FSEL;
      default: a = 8'hff;
    endcase
    port_addr = a;
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Everything clears, function selects included, so pins start as plain ports
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sfr_rdata = s_q.rdata;
  assign pin_out = s_q.o;
  assign pin_oe = s_q.oe;
  assign pin_pullup = s_q.pull;
  assign pin_func_sel = s_q.fsel;
  assign key_wake_inputs = s_q.key;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence wr_s(logic [7:0] a);
    sfr_wr && sfr_addr == a;
  endsequence
  od_drive_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    (s_q.od[2][0] && s_q.data[2][0]) |=> !pin_oe[16])
    else $error("open-drain pin drove high");
  debounce_clock_select_fx4_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    (dbsel == GPD_DB_FX4 && $stable(dbsel) && s_q.tick) |-> ##1 !s_q.tick ##1 !s_q.tick ##1 !s_q.tick)
    else $error("fx/4 tick spacing wrong");
  debounce_clock_select_fx1_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    (dbsel == GPD_DB_FX1) ##1 (dbsel == GPD_DB_FX1) |-> s_q.tick)
    else $error("fx/1 tick missing");
  port0_debounce_control_rsvd_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    (s_q.port0_debounce_control & ~`GPD_PORT0_DEBOUNCE_CONTROL_MASK) == 8'h00)
    else $error("reserved debounce bits set");
  port0_debounce_control_write_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    wr_s(`GPD_A_P0_DB) |=> s_q.port0_debounce_control[1:0] == $past(sfr_wdata[1:0]))
    else $error("pin filter enables not stored");
  dir_oe_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    (!s_q.dir[3][2]) |=> !pin_oe[26])
    else $error("input pin driven");
  pullup_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    wr_s(`GPD_A_P4_PU) |-> ##2 pin_pullup[39:32] == $past(sfr_wdata, 2))
    else $error("pull-up not applied");
  key_gate_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    s_q.dir[1][3] |=> key_wake_inputs[3])
    else $error("key active on output pin");
  read_in_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    (sfr_rd && sfr_addr == `GPD_A_P2_DATA && s_q.dir[2] == 8'h00) |=> sfr_rdata == $past(pin_in[23:16]))
    else $error("input read mismatch");
endmodule // gpd_top

// *** rtl/gpd_consts.svh ***
`ifndef GPD_CONSTS_SVH
`define GPD_CONSTS_SVH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define GPD_A_P0_DATA 8'h80
`define GPD_A_P0_DIR 8'h89
`define GPD_A_P0_PU 8'hd4
`define GPD_A_P0_OD 8'h92
`define GPD_A_P0_FSEL 8'hed
`define GPD_A_P1_DATA 8'h88
`define GPD_A_P2_DATA 8'h90
`define GPD_A_P1_DIR 8'h91
`define GPD_A_P1_OD 8'h93
`define GPD_A_P2_OD 8'h94
`define GPD_A_P3_OD 8'h95
`define GPD_A_P4_OD 8'h96
`define GPD_A_P5_OD 8'h9a
`define GPD_A_P3_DATA 8'h98
`define GPD_A_P2_DIR 8'h99
`define GPD_A_P4_DATA 8'ha0
`define GPD_A_P3_DIR 8'ha1
`define GPD_A_P5_DATA 8'hb0
`define GPD_A_P4_DIR 8'hb1
`define GPD_A_P5_DIR 8'hb9
`define GPD_A_P1_PU 8'hd5
`define GPD_A_P2_PU 8'hd6
`define GPD_A_P3_PU 8'hd7
`define GPD_A_P4_PU 8'hda
`define GPD_A_P5_PU 8'hdb
`define GPD_A_P0_DB 8'he9
`define GPD_A_P1_DB 8'hea
`define GPD_A_P2_FSEL 8'hee
`define GPD_A_P3_FSEL 8'hef
`define GPD_A_P4_FSEL 8'hf1
`define GPD_A_P5_FSEL 8'hf2
// ----------------------------------------
// Fields and values
// ----------------------------------------
`define GPD_RST_BYTE 8'h00
`define GPD_PORT0_DEBOUNCE_CONTROL_MASK 8'hc3
`define GPD_P0FSEL_MASK 8'h3f
`define GPD_DEBOUNCE_CLOCK_SELECT_HI 7
`define GPD_DEBOUNCE_CLOCK_SELECT_LO 6
`define GPD_PIN5_EN_BIT 1
`define GPD_PIN0_EN_BIT 0
`define GPD_DIV_FX4 12'd4
`define GPD_DIV_FX4096 13'd4096
`define GPD_DB_COUNT 2'd3
`endif

// *** rtl/gpd_pkg.sv ***
package gpd_pkg;
  // Debounce clock select codes
  typedef enum logic [1:0] {
    GPD_DB_FX1 = 2'b00,
    GPD_DB_FX4 = 2'b01,
    GPD_DB_FX4096 = 2'b10,
    GPD_DB_RSVD = 2'b11
  } gpd_debounce_clock_select_type;
  typedef logic [7:0] gpd_byte_type;
endpackage

// *** rtl/gpd_filter.sv ***
`timescale 1ns/10ps
`include "gpd_consts.svh"
// Per-pin debounce filter: accepts a level after three equal samples
module gpd_filter
  import gpd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_in,
  input wire logic sample_en,
  input wire logic filter_en,
  input wire logic stop_mode,
  output logic pin_out
);
  typedef struct packed {
    logic level;
    logic [1:0] cnt;
  } gpd_filt_type;
  gpd_filt_type s_q, s_d;
  // ----------------------------------------
  // Filter state
  // ----------------------------------------
  // Bypassed while disabled or in stop; count restarts so old samples never count
  always_comb begin
    s_d = s_q;
    if (!filter_en || stop_mode) begin
      s_d.level = pin_in;
      s_d.cnt = 2'd0;
    end else if (sample_en) begin
      if (pin_in == s_q.level) begin
        s_d.cnt = 2'd0;
      end else if (s_q.cnt == `GPD_DB_COUNT - 2'd1) begin
        s_d.level = pin_in;
        s_d.cnt = 2'd0;
      end else begin
        s_d.cnt = s_q.cnt + 2'd1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign pin_out = s_q.level;
  // Level moves only on a sample tick while filtering
  filt_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (filter_en && !stop_mode && $past(filter_en) && !$past(stop_mode) && $changed(pin_out))
      |-> $past(sample_en))
    else $error("filtered level changed without a sample");
  filt_bypass_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!filter_en) |=> (pin_out == $past(pin_in)))
    else $error("bypassed filter did not follow pin");
endmodule // gpd_filter

// *** testbench/gpd_board.sv ***
`timescale 1ns/10ps
// Board side of the pins: external drivers, pull-ups and floating lines
module gpd_board (
  input wire logic clk,
  input wire logic [47:0] pin_out,
  input wire logic [47:0] pin_oe,
  input wire logic [47:0] pin_pullup,
  input wire logic [47:0] ext_drive,
  input wire logic [47:0] ext_en,
  output logic [47:0] pin_level
);
  logic float_q = 1'b0;
  // An undriven line wanders, so it never keeps its last value
  always @(posedge clk) begin
    float_q <= ~float_q;
  end
  // Device driver first, then the board, then the pull-up
  always_comb begin
    for (int i = 0; i < 48; i++) begin
      if (pin_oe[i]) begin
        pin_level[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_level[i] = ext_drive[i];
      end else if (pin_pullup[i]) begin
        pin_level[i] = 1'b1;
      end else begin
        pin_level[i] = float_q;
      end
    end
  end
endmodule // gpd_board

// *** testbench/tb_gpd_top.sv ***
`timescale 1ns/10ps
module tb_gpd_top
  import gpd_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic stop_mode = 1'b0;
  logic [47:0] pin_level, pin_out, pin_oe, pin_pullup, pin_func_sel;
  logic [47:0] ext_drive = 48'h0;
  logic [47:0] ext_en = {48{1'b1}};
  logic [7:0] key_wake_inputs;
  logic [7:0] da [5] = '{8'h88, 8'h90, 8'h98, 8'ha0, 8'hb0};
  logic [7:0] di [5] = '{8'h91, 8'h99, 8'ha1, 8'hb1, 8'hb9};
  logic [7:0] od [5] = '{8'h93, 8'h94, 8'h95, 8'h96, 8'h9a};
  logic [7:0] pu [5] = '{8'hd5, 8'hd6, 8'hd7, 8'hda, 8'hdb};
  logic [7:0] v;
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;

  // Short slow divider keeps the fx/4096 case brief
  gpd_top #(.NPORT(6), .SLOW_DIV(8)) u_gpd_top (.clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .stop_mode(stop_mode), .pin_in(pin_level), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .pin_func_sel(pin_func_sel), .key_wake_inputs(key_wake_inputs));
  gpd_board u_gpd_board (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .ext_drive(ext_drive), .ext_en(ext_en), .pin_level(pin_level));

  // 20 MHz clock
  always #25 clk = ~clk;

  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask

  // Whole-byte read, masking done by the caller
  task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1;
    check(sfr_rdata, exp, "register read");
  endtask

  // Pulse on port 1 pins, then report every filtered level that rose
  task automatic pulse(input logic [7:0] mask, input int len, input logic [7:0] exp);
    logic [7:0] seen;
    seen = 8'h00;
    @(posedge clk);
    ext_drive[15:8] <= mask;
    for (int i = 0; i < len + 30; i++) begin
      @(posedge clk);
      if (i == len - 1) begin
        ext_drive[15:8] <= 8'h00;
      end
      seen = seen | key_wake_inputs;
    end
    check(seen, exp, "filtered pulse");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    sfr_read(8'he9, 8'h00);
    sfr_read(8'hea, 8'h00);
    sfr_write(8'he9, 8'hff);
    sfr_read(8'he9, 8'hc3);
    sfr_write(8'h81, 8'h55);
    sfr_read(8'h81, 8'h00);
    // Ports 1 to 5: reset values, drive modes, read-back of latch and pins
    for (int p = 1; p <= 5; p++) begin
      v = 8'h3c ^ 8'(p * 17);
      sfr_read(da[p-1], 8'h00);
      sfr_read(di[p-1], 8'h00);
      sfr_read(od[p-1], 8'h00);
      sfr_read(pu[p-1], 8'h00);
      check(pin_func_sel[8*p +: 8], 8'h00, "function select");
      sfr_write(da[p-1], v);
      sfr_write(di[p-1], 8'hff);
      sfr_write(od[p-1], 8'h0f);
      sfr_write(pu[p-1], v);
      repeat (3) @(posedge clk);
      check(pin_oe[8*p +: 8], ~(8'h0f & v), "output enable");
      check(pin_out[8*p +: 8], v & 8'hf0, "output level");
      check(pin_pullup[8*p +: 8], v, "pull-up");
      sfr_read(da[p-1], v);
      ext_drive[8*p +: 8] <= ~v;
      sfr_write(di[p-1], 8'h00);
      sfr_write(od[p-1], 8'h00);
      sfr_write(pu[p-1], 8'h00);
      repeat (8) @(posedge clk);
      sfr_read(da[p-1], ~v);
      ext_drive[8*p +: 8] <= 8'h00;
    end
    // Released port 3 lines settle at the pull-up level
    ext_en[31:24] <= 8'h00;
    sfr_write(8'hd7, 8'hff);
    repeat (8) @(posedge clk);
    sfr_read(8'h98, 8'hff);
    sfr_write(8'hd7, 8'h00);
    ext_en[31:24] <= 8'hff;
    // Port 0: pins 0 and 5 filtered on the slow clock, pin 1 not
    sfr_write(8'he9, {GPD_DB_FX4096, 6'h03});
    ext_drive[7:0] <= 8'h23;
    repeat (6) @(posedge clk);
    sfr_read(8'h80, 8'h02);
    repeat (40) @(posedge clk);
    sfr_read(8'h80, 8'h23);
    ext_drive[7:0] <= 8'h00;
    // Port 1 filters on pins 0 to 3, clock taken from port 0 field
    sfr_write(8'hea, 8'h0f);
    sfr_write(8'he9, {GPD_DB_FX1, 6'h00});
    pulse(8'h11, 2, 8'h10);
    pulse(8'h01, 3, 8'h01);
    sfr_write(8'he9, {GPD_DB_FX4, 6'h00});
    pulse(8'h01, 8, 8'h00);
    pulse(8'h01, 16, 8'h01);
    sfr_write(8'he9, {GPD_DB_FX4096, 6'h00});
    pulse(8'h01, 16, 8'h00);
    pulse(8'h01, 40, 8'h01);
    sfr_write(8'he9, {GPD_DB_RSVD, 6'h00});
    stop_mode <= 1'b1;
    pulse(8'h01, 2, 8'h01);
    stop_mode <= 1'b0;
    pulse(8'h01, 40, 8'h00);
    // Key inputs stay inactive-high on an output pin
    sfr_write(8'h91, 8'h80);
    repeat (4) @(posedge clk);
    check(key_wake_inputs & 8'h80, 8'h80, "key on output pin");
    finish_test();
  end
endmodule // tb_gpd_top
